// ==== core/tcp_defs.svh ====
// Offsets, field positions, reset values and timing counts of the timer
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// ***************************************************************
// Addresses and fields
// ***************************************************************
`define COUNT_ADDR 5'h01
`define OPT_WAKE_BIT 7
`define OPT_PULL_BIT 6
`define OPT_CS_BIT 5
`define OPT_SE_BIT 4
`define OPT_PSA_BIT 3
`define OPT_RATIO_HI 2
`define OPT_RATIO_LO 0
`define PIN_A_BIT 2
`define PIN_C_BIT 5

// ***************************************************************
// Reset values
// ***************************************************************
`define OPT_RESET 8'hff
`define DIR_RESET 6'h3f
`define COUNT_POR 8'h00
`define PRE_RESET 8'h00

// ***************************************************************
// Timing
// ***************************************************************
`define TOSC_PER_INSTR 4
`define INHIBIT_INSTR 2
`define INHIBIT_CYC (`INHIBIT_INSTR * `TOSC_PER_INSTR)
`define SYNC_MIN_TOSC 3
`define SYNC_MAX_TOSC 7

`endif

// ==== core/tcp_pkg.sv ====
// Types shared by the timer counter with prescaler
package tcp_pkg;

  // Gray order along the phase loop
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } tcp_phase_t;

  typedef struct packed {
    tcp_phase_t phase;
    logic [7:0] opt;
    logic [5:0] dir_a;
    logic [5:0] dir_c;
    logic [5:0] dir_a_out;
    logic [5:0] dir_c_out;
    logic [7:0] count;
    logic [7:0] pre;
    logic pin_prev;
    logic samp;
    logic samp_prev;
    logic [3:0] inhibit;
    logic wdt_out;
  } tcp_state_t;

endpackage

// ==== core/tcp_timer_counter.sv ====
// Timer counter with shared prescaler, phase clocks and pin override
`timescale 1ns/1ps
`include "tcp_defs.svh"

module tcp_timer_counter (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sys_reset,
  input wire logic [4:0] file_addr,
  input wire logic file_wr_en,
  input wire logic [7:0] file_wr_data,
  input wire logic option_load,
  input wire logic dir_a_load,
  input wire logic dir_c_load,
  input wire logic [7:0] load_data,
  input wire logic watchdog_clear,
  input wire logic wdt_tick,
  input wire logic external_count_pin,
  output logic [7:0] count_rd_data,
  output logic [5:0] dir_a_out,
  output logic [5:0] dir_c_out,
  output logic wake_on_change_disable_a,
  output logic pullup_disable_a,
  output logic wdt_post_tick
);
  import tcp_pkg::*;

  // ***************************************************************
  // State and decode
  // ***************************************************************
  tcp_state_t st_reg;
  tcp_state_t st_next;

  logic count_wr;
  logic clock_source_select;
  logic count_edge_select;
  logic prescaler_assign;
  logic [2:0] prescale_ratio_field;
  logic [7:0] ratio_mask;
  logic [7:0] wdt_mask;
  logic pin_lvl;
  logic pin_prev_lvl;
  logic sel_edge;
  logic src;
  logic sample_ph;
  logic timer_tick;
  logic sync_rise;
  logic inc_req;
  logic cnt_inc;

  assign count_wr = file_wr_en && (file_addr == `COUNT_ADDR);
  assign clock_source_select = st_reg.opt[`OPT_CS_BIT];
  assign count_edge_select = st_reg.opt[`OPT_SE_BIT];
  assign prescaler_assign = st_reg.opt[`OPT_PSA_BIT];
  assign prescale_ratio_field = st_reg.opt[`OPT_RATIO_HI:`OPT_RATIO_LO];

  // Low n+1 bits for the counter, low n bits for the watchdog
  assign ratio_mask = ~(8'hfe << prescale_ratio_field);
  assign wdt_mask = ~(8'hff << prescale_ratio_field);

  // Falling edges become rising ones by inverting the pin
  assign pin_lvl = external_count_pin ^ count_edge_select;
  assign pin_prev_lvl = st_reg.pin_prev ^ count_edge_select;
  assign sel_edge = pin_lvl && !pin_prev_lvl;

  // Prescaler bit n is symmetric, so it is sampled like the pin
  assign src = prescaler_assign ? pin_lvl
                                : st_reg.pre[prescale_ratio_field];
  assign sample_ph = (st_reg.phase == PH_Q2) ||
                     (st_reg.phase == PH_Q4);
  assign timer_tick = (st_reg.phase == PH_Q4);
  assign sync_rise = st_reg.samp && !st_reg.samp_prev;

  always_comb begin
    if (clock_source_select) begin
      inc_req = sample_ph && sync_rise;
    end else if (prescaler_assign) begin
      inc_req = timer_tick;
    end else begin
      inc_req = timer_tick &&
                ((st_reg.pre | ~ratio_mask) == 8'hff);
    end
  end

  assign cnt_inc = inc_req && (st_reg.inhibit == 4'h0);

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      PH_Q1: begin
        st_next.phase = PH_Q2;
      end
      PH_Q2: begin
        st_next.phase = PH_Q3;
      end
      PH_Q3: begin
        st_next.phase = PH_Q4;
      end
      PH_Q4: begin
        st_next.phase = PH_Q1;
      end
      default: begin
        st_next.phase = PH_Q1;
      end
    endcase

    st_next.pin_prev = external_count_pin;
    if (sample_ph) begin
      st_next.samp = src;
      st_next.samp_prev = st_reg.samp;
    end
    if (st_reg.inhibit != 4'h0) begin
      st_next.inhibit = st_reg.inhibit - 4'h1;
    end
    if (cnt_inc) begin
      st_next.count = st_reg.count + 8'h01;
    end

    // One counter, one owner at a time
    st_next.wdt_out = wdt_tick;
    if (!prescaler_assign) begin
      if (clock_source_select ? sel_edge : timer_tick) begin
        st_next.pre = st_reg.pre + 8'h01;
      end
    end else begin
      st_next.wdt_out = wdt_tick &&
                        ((st_reg.pre & wdt_mask) == wdt_mask);
      if (wdt_tick) begin
        st_next.pre = st_reg.pre + 8'h01;
      end
    end

    if (count_wr) begin
      st_next.count = file_wr_data;
      st_next.inhibit = 4'(`INHIBIT_CYC);
      if (!prescaler_assign) begin
        st_next.pre = `PRE_RESET;
      end
    end
    if (watchdog_clear && prescaler_assign) begin
      st_next.pre = `PRE_RESET;
    end

    // Loaded from the working register only, never read back
    if (option_load) begin
      st_next.opt = load_data;
    end
    if (dir_a_load) begin
      st_next.dir_a = load_data[5:0];
    end
    if (dir_c_load) begin
      st_next.dir_c = load_data[5:0];
    end

    // Other resets keep the count value
    if (sys_reset) begin
      st_next.opt = `OPT_RESET;
      st_next.dir_a = `DIR_RESET;
      st_next.dir_c = `DIR_RESET;
      st_next.pre = `PRE_RESET;
      st_next.inhibit = 4'h0;
      // Held high so only a sampled low then high counts
      st_next.samp = 1'b1;
      st_next.samp_prev = 1'b1;
      st_next.wdt_out = 1'b0;
      st_next.count = st_reg.count;
    end

    st_next.dir_a_out = st_next.dir_a;
    st_next.dir_c_out = st_next.dir_c;
    if (st_next.opt[`OPT_CS_BIT]) begin
      st_next.dir_a_out[`PIN_A_BIT] = 1'b1;
      st_next.dir_c_out[`PIN_C_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{phase: PH_Q1, opt: `OPT_RESET, dir_a: `DIR_RESET,
                  dir_c: `DIR_RESET, dir_a_out: `DIR_RESET,
                  dir_c_out: `DIR_RESET, count: `COUNT_POR,
                  pre: `PRE_RESET, pin_prev: 1'b0, samp: 1'b1,
                  samp_prev: 1'b1, inhibit: 4'h0,
                  wdt_out: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign count_rd_data = st_reg.count;
  assign dir_a_out = st_reg.dir_a_out;
  assign dir_c_out = st_reg.dir_c_out;
  assign wake_on_change_disable_a = st_reg.opt[`OPT_WAKE_BIT];
  assign pullup_disable_a = st_reg.opt[`OPT_PULL_BIT];
  assign wdt_post_tick = st_reg.wdt_out;

  // ***************************************************************
  // Checks
  // ***************************************************************
  // Cycles since the sampled source last rose, and since options moved
  logic src_d;
  logic [2:0] src_age;
  logic [2:0] opt_age;
  logic quiet;

  assign quiet = !count_wr && !option_load && !sys_reset &&
                 (st_reg.inhibit == 4'h0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_d <= 1'b1;
      src_age <= 3'h7;
      opt_age <= 3'h0;
    end else begin
      src_d <= src;
      if (src && !src_d) begin
        src_age <= 3'h1;
      end else if (src_age != 3'h7) begin
        src_age <= src_age + 3'h1;
      end
      if (option_load || sys_reset) begin
        opt_age <= 3'h0;
      end else if (opt_age != 3'h7) begin
        opt_age <= opt_age + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  timer_step_a: assert property (
    (!clock_source_select && prescaler_assign && timer_tick && quiet)
    |=> count_rd_data == 8'($past(count_rd_data) + 8'h01))
    else $error("timer mode missed its instruction step");

  inhibit_load_a: assert property (
    (count_wr && !sys_reset) |=> st_reg.inhibit == 4'(`INHIBIT_CYC))
    else $error("count write did not arm the hold-off");

  inhibit_hold_a: assert property (
    (st_reg.inhibit != 4'h0 && !count_wr && !sys_reset)
    |=> $stable(count_rd_data))
    else $error("count moved during write hold-off");

  count_write_a: assert property (
    (count_wr && !sys_reset) |=> count_rd_data == $past(file_wr_data))
    else $error("count write not taken");

  sync_delay_a: assert property (
    (clock_source_select && cnt_inc && opt_age == 3'h7)
    |-> (src_age >= 3'(`SYNC_MIN_TOSC - 1)) &&
        (src_age <= 3'(`SYNC_MIN_TOSC)))
    else $error("pin increment outside sampling window");

  edge_count_a: assert property (
    (clock_source_select && src && !src_d && quiet && opt_age == 3'h7)
    ##1 (quiet && !cnt_inc) [*3] |-> 1'b0)
    else $error("selected pin edge was not counted");

  ratio_gate_a: assert property (
    (!clock_source_select && !prescaler_assign && cnt_inc)
    |-> timer_tick && ((st_reg.pre & ratio_mask) == ratio_mask))
    else $error("prescaled timer stepped off its ratio");

  owner_sep_a: assert property (
    (prescaler_assign && !wdt_tick && !watchdog_clear && !sys_reset &&
     !option_load) |=> $stable(st_reg.pre))
    else $error("prescaler advanced for the wrong owner");

  wdt_bypass_a: assert property (
    (!prescaler_assign && !sys_reset) |=> wdt_post_tick == $past(wdt_tick))
    else $error("watchdog tick altered without prescaler");

  pre_clear_a: assert property (
    (count_wr && !prescaler_assign) |=> st_reg.pre == `PRE_RESET)
    else $error("count write left prescaler set");

  wdt_clear_a: assert property (
    (watchdog_clear && prescaler_assign) |=> st_reg.pre == `PRE_RESET)
    else $error("watchdog clear left prescaler set");

  soft_reset_a: assert property (
    sys_reset |=> (st_reg.pre == `PRE_RESET) && $stable(count_rd_data))
    else $error("reset did not clear prescaler or lost count");

  pin_force_a: assert property (
    $rose(st_reg.opt[`OPT_CS_BIT]) |->
    dir_a_out[`PIN_A_BIT] && dir_c_out[`PIN_C_BIT])
    else $error("count pin not forced to input");

  // A source already high at reset must not look like an edge
  pin_cause_a: assert property (
    (clock_source_select && cnt_inc) |-> src_age <= 3'h3)
    else $error("pin count step without a source edge");

  timer_idle_a: assert property (
    (!clock_source_select && prescaler_assign && !timer_tick && quiet)
    |=> $stable(count_rd_data))
    else $error("timer stepped outside its instruction step");

  count_wrap_a: assert property (
    (cnt_inc && !count_wr && !sys_reset && count_rd_data == 8'hff)
    |=> count_rd_data == 8'h00)
    else $error("count did not wrap to zero");

  wdt_quiet_a: assert property (
    (prescaler_assign && !wdt_tick && !sys_reset) |=> !wdt_post_tick)
    else $error("postscaler pulsed without a watchdog tick");

  dir_follow_a: assert property (
    !clock_source_select |->
    (dir_a_out == st_reg.dir_a) && (dir_c_out == st_reg.dir_c))
    else $error("direction outputs left their loaded values");

endmodule // tcp_timer_counter

// ==== test/tcp_pin_source.sv ====
// Model of the external count source on the count pin
`timescale 1ns/1ps
module tcp_pin_source (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] half,
  output logic pin
);
  logic [7:0] cnt;
  initial begin
    pin = 1'b0;
    cnt = 8'h00;
  end
  // Caller keeps half at two or more; the pin holds still when stopped
  always @(negedge clk) begin
    if (run) begin
      cnt <= cnt + 8'h01;
      if (cnt + 8'h01 >= half) begin
        cnt <= 8'h00;
        pin <= ~pin;
      end
    end
  end
endmodule // tcp_pin_source

// ==== test/test_tcp_timer_counter.sv ====
// Self-checking bench for the timer counter with prescaler
`timescale 1ns/1ps
`include "tcp_defs.svh"
module test_tcp_timer_counter;
  logic clk, arst_n, sys_reset, file_wr_en, option_load, dir_a_load;
  logic dir_c_load, watchdog_clear, wdt_tick, pin, run;
  logic wake, pull, wdt_post_tick;
  logic [4:0] file_addr;
  logic [7:0] file_wr_data, load_data, count_rd_data, half, v0;
  logic [5:0] dir_a_out, dir_c_out;
  int n_errors = 0;
  int n_tests = 0;
  int n_post = 0;
  int cycles = 0;
  int p0, lat;

  tcp_timer_counter i_tcp_timer_counter (.clk(clk), .arst_n(arst_n),
    .sys_reset(sys_reset), .file_addr(file_addr), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .option_load(option_load),
    .dir_a_load(dir_a_load), .dir_c_load(dir_c_load),
    .load_data(load_data), .watchdog_clear(watchdog_clear),
    .wdt_tick(wdt_tick), .external_count_pin(pin),
    .count_rd_data(count_rd_data), .dir_a_out(dir_a_out),
    .dir_c_out(dir_c_out), .wake_on_change_disable_a(wake),
    .pullup_disable_a(pull), .wdt_post_tick(wdt_post_tick));
  tcp_pin_source i_tcp_pin_source (.clk(clk), .run(run), .half(half),
    .pin(pin));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    file_addr = a;
    file_wr_data = d;
    file_wr_en = 1'b1;
    @(negedge clk);
    file_wr_en = 1'b0;
  endtask
  task automatic load(input logic [2:0] sel, input logic [7:0] d);
    @(negedge clk);
    {dir_c_load, dir_a_load, option_load} = sel;
    load_data = d;
    @(negedge clk);
    {dir_c_load, dir_a_load, option_load} = 3'b000;
  endtask
  task automatic wdt(input logic clr);
    @(negedge clk);
    watchdog_clear = clr;
    wdt_tick = ~clr;
    @(negedge clk);
    watchdog_clear = 1'b0;
    wdt_tick = 1'b0;
  endtask
  // Rate windows are a whole number of periods, so phase does not matter; the 7-cycle one follows an unselected edge
  task automatic delta(input int cyc, input logic [7:0] exp);
    v0 = count_rd_data;
    tick(cyc);
    check("count steps", count_rd_data - v0, exp);
  endtask
  always @(posedge clk) begin
    if (wdt_post_tick === 1'b1) n_post <= n_post + 1;
  end

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset;
    check("option top", {6'h00, wake, pull}, 8'h03);
    check("dir a", {2'b00, dir_a_out}, {2'b00, `DIR_RESET});
    check("count", count_rd_data, `COUNT_POR);
    tick(12);
    check("count idle", count_rd_data, `COUNT_POR);
  endtask
  task automatic t_timer;
    load(3'b001, 8'h08);
    wr(`COUNT_ADDR, 8'hfd);
    for (int i = 0; i < 9; i++) begin
      check("held", count_rd_data, 8'hfd);
      tick(1);
    end
    delta(16, 8'h04);
  endtask
  task automatic t_ratio;
    wdt(1'b1);
    for (int i = 0; i < 8; i++) begin
      load(3'b001, {5'h00, i[2:0]});
      delta(16 << i, 8'h02);
    end
    tick(400);
    wr(`COUNT_ADDR, 8'h00);
    tick(1010);
    check("cleared pre", count_rd_data, 8'h00);
    tick(30);
    check("cleared pre", count_rd_data, 8'h01);
  endtask
  task automatic t_wdt;
    wdt(1'b1);
    wr(`COUNT_ADDR, 8'h00);
    load(3'b001, 8'h0f);
    wdt(1'b1);
    load(3'b001, 8'h09);
    p0 = n_post;
    repeat (4) wdt(1'b0);
    tick(2);
    check("postscale", 8'(n_post - p0), 8'h02);
    delta(8, 8'h02);
    p0 = n_post;
    wdt(1'b0);
    wdt(1'b1);
    wdt(1'b0);
    tick(2);
    check("wdt clear", 8'(n_post - p0), 8'h00);
    wdt(1'b1);
    load(3'b001, 8'h00);
    p0 = n_post;
    repeat (3) wdt(1'b0);
    tick(2);
    check("wdt direct", 8'(n_post - p0), 8'h03);
  endtask
  task automatic t_pin;
    load(3'b110, 8'h00);
    check("dir a", {2'b00, dir_a_out}, 8'h00);
    load(3'b001, 8'h28);
    check("pin a", {2'b00, dir_a_out}, 8'h04);
    check("pin c", {2'b00, dir_c_out}, 8'h20);
    check("option top", {6'h00, wake, pull}, 8'h00);
    run = 1'b1;
    for (int se = 0; se < 2; se++) begin
      load(3'b001, se[0] ? 8'h38 : 8'h28);
      if (se[0]) @(negedge pin);
      else @(posedge pin);
      v0 = count_rd_data;
      lat = 0;
      while (count_rd_data === v0 && lat < 9) begin
        tick(1);
        lat++;
      end
      check("latency ok", {7'h00, lat >= 3 && lat <= 7}, 8'h01);
      if (se[0]) @(posedge pin);
      else @(negedge pin);
      delta(7, 8'h00);
    end
    half = 8'd4;
    delta(64, 8'h08);
    wdt(1'b1);
    load(3'b001, 8'h21);
    delta(128, 8'h04);
    run = 1'b0;
  endtask
  task automatic t_sysrst;
    tick(12);
    wr(`COUNT_ADDR, 8'h5a);
    wr(5'h02, 8'h11);
    tick(10);
    check("other addr", count_rd_data, 8'h5a);
    @(negedge clk);
    sys_reset = 1'b1;
    @(negedge clk);
    sys_reset = 1'b0;
    check("kept", count_rd_data, 8'h5a);
    check("opt reset", {6'h00, wake, pull}, 8'h03);
    check("dir reset", {2'b00, dir_c_out}, 8'h3f);
    tick(12);
    check("kept idle", count_rd_data, 8'h5a);
  endtask

  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run needs about six thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    {arst_n, sys_reset, file_wr_en, option_load, dir_a_load} = 5'h00;
    {dir_c_load, watchdog_clear, wdt_tick, run} = 4'h0;
    file_addr = 5'h00;
    file_wr_data = 8'h00;
    load_data = 8'h00;
    half = 8'd8;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    t_reset;
    t_timer;
    t_ratio;
    t_wdt;
    t_pin;
    t_sysrst;
    close_out;
  end
endmodule // test_tcp_timer_counter
